// ==== logic/bidirectional_gpio_ports.sv ====
// Parallel port block: latches, direction registers, pin drivers and APB slave
`default_nettype none
module bidirectional_gpio_ports
	import gpio_ports_pkg::*;
(
	input wire logic clk, // 10 MHz system clock
	input wire logic srst, // Synchronous reset, active high
	input wire apb_req_type apbReq, // APB request bundle
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [7:0] firstPortIn, // First port pin levels
	output logic [7:0] firstPortOut, // First port drive values
	output logic [7:0] firstPortOutEnN, // First port enable, low drives
	input wire logic [7:0] secondPortIn, // Second port pin levels
	output logic [7:0] secondPortOut, // Second port drive values
	output logic [7:0] secondPortOutEnN, // Second port enable, low drives
	input wire logic [6:0] thirdPortIn, // Third port pin levels
	output logic [6:0] thirdPortOut, // Third port drive values
	output logic [6:0] thirdPortOutEnN, // Third port enable, low drives
	input wire logic [7:0] fifthPortIn, // Fifth port pin levels
	output logic [7:0] fifthPortOut, // Fifth port drive values
	output logic [7:0] fifthPortOutEnN, // Fifth port enable, low drives
	input wire logic [5:0] sixthPortIn, // Sixth port pin levels
	output logic [5:0] sixthPortOut, // Sixth port drive values
	output logic [5:0] sixthPortOutEnN // Sixth port enable, low drives
);
	// ****************************************
	// How the block works
	// ****************************************
	// Five ports sit behind one APB slave: first, second, third, fifth and sixth.
	// Each port owns a byte of latch and a byte of direction, kept in arrays
	// indexed by a slot number, so one decode serves every register.
	// A direction bit of one turns the pin driver on and makes a read of the
	// data register return the latch; a zero floats the pin and a read returns
	// whatever the board holds on it.
	// The latches are written on every data write, input or output alike, so
	// software can preload a value before it turns the driver on.
	// Latches carry no reset: a system reset that strikes while outputs drive
	// must not lose what software left there. Directions do reset, which floats
	// every pin at once and keeps the board safe from a driver fight.
	// Driver enables are separate flops written on the same edge as the
	// direction, so the pad enables come straight from a register.
	// Pins are sampled directly with no synchroniser; the board side must hold
	// them steady to the clock, or a read may see a level in motion.
	// Narrow ports keep their unused bit positions at zero in both arrays;
	// writes to them are masked away and reads return zero.
	// Addresses outside the map answer with an error and change nothing.
	// Every transfer completes with no wait state: ready follows setup by one
	// clock, and read data is taken from the state seen in the setup cycle.

	// ****************************************
	// Limits and hazards
	// ****************************************
	// A direction bit turned on before its latch is loaded drives a stale
	// value for at least one clock; the hardware does not guard this order.
	// A latch never written reads back unknown in simulation wherever its
	// direction bit is set, since it has no reset value.
	// Unaligned addresses and addresses with high bits set count as holes.
	// Only the low byte of write data is used; the rest is ignored.
	// The enable flops duplicate the direction bits; the two must only ever
	// be written together, or the pins and the readback will disagree.

	// ****************************************
	// Helper functions
	// ****************************************

	// Map a byte address onto a register slot; unaligned or hole means no hit
	function automatic decode_type decodeAddr(input logic [7:0] addr);
		decode_type d;
		d = '0;
		if (addr[1:0] == 2'b00) begin
			d.hit = 1'b1;
			unique case (addr[5:2])
				IDX_FIRST_LATCH: d.slot = SLOT_FIRST;
				IDX_SECOND_LATCH: d.slot = SLOT_SECOND;
				IDX_THIRD_LATCH: d.slot = SLOT_THIRD;
				IDX_FIRST_DIR: begin
					d.slot = SLOT_FIRST;
					d.isDir = 1'b1;
				end
				IDX_SECOND_DIR: begin
					d.slot = SLOT_SECOND;
					d.isDir = 1'b1;
				end
				IDX_THIRD_DIR: begin
					d.slot = SLOT_THIRD;
					d.isDir = 1'b1;
				end
				IDX_FIFTH_LATCH: d.slot = SLOT_FIFTH;
				IDX_SIXTH_LATCH: d.slot = SLOT_SIXTH;
				IDX_FIFTH_DIR: begin
					d.slot = SLOT_FIFTH;
					d.isDir = 1'b1;
				end
				IDX_SIXTH_DIR: begin
					d.slot = SLOT_SIXTH;
					d.isDir = 1'b1;
				end
				default: d.hit = 1'b0;
			endcase
			if (addr[7:6] != 2'b00) begin
				d.hit = 1'b0; // Upper address bits must be zero
			end
		end
		return d;
	endfunction

	// Implemented bits of a port; the rest ignore writes and read zero
	function automatic logic [7:0] slotMask(input logic [2:0] slot);
		logic [7:0] m;
		m = 8'h00;
		unique case (slot)
			SLOT_FIRST: m = MASK_FIRST;
			SLOT_SECOND: m = MASK_SECOND;
			SLOT_THIRD: m = MASK_THIRD;
			SLOT_FIFTH: m = MASK_FIFTH;
			SLOT_SIXTH: m = MASK_SIXTH;
			default: m = 8'h00; // Slot codes 5..7 never decoded
		endcase
		return m;
	endfunction

	// Per bit: output bits return the latch, input bits the pin
	function automatic logic [7:0] readMux(input logic [7:0] lat, input logic [7:0] dr,
		input logic [7:0] pin);
		return (dr & lat) | (~dr & pin);
	endfunction

	// ****************************************
	// Storage and decode
	// ****************************************
	logic [7:0] latch [NUM_PORTS]; // Data latches, never reset
	logic [7:0] dir [NUM_PORTS]; // Direction bits, one means output
	logic [7:0] outEnN [NUM_PORTS]; // Registered driver enables, low drives
	logic [7:0] pins [NUM_PORTS]; // Pin levels widened to a byte
	decode_type dec; // Decode of the current address
	logic [7:0] slotM; // Mask of the addressed port
	logic wrAccept; // Write takes effect on this edge
	logic [7:0] rdValue; // Value a read of the address returns

	assign pins[SLOT_FIRST] = firstPortIn;
	assign pins[SLOT_SECOND] = secondPortIn;
	assign pins[SLOT_THIRD] = {1'b0, thirdPortIn};
	assign pins[SLOT_FIFTH] = fifthPortIn;
	assign pins[SLOT_SIXTH] = {2'b00, sixthPortIn};
	assign dec = decodeAddr(apbReq.paddr);
	assign slotM = slotMask(dec.slot);
	// Writes land only on the completing access edge
	assign wrAccept = apbReq.psel && apbReq.penable && pready && apbReq.pwrite;

	// Read value of the addressed register, reserved bits forced to zero
	always_comb begin
		rdValue = 8'h00;
		if (dec.hit) begin
			if (dec.isDir) begin
				rdValue = dir[dec.slot] & slotM;
			end else begin
				rdValue = readMux(latch[dec.slot], dir[dec.slot], pins[dec.slot]) & slotM;
			end
		end
	end

	// ****************************************
	// Data latches
	// ****************************************

	// No reset branch on purpose: latch contents survive reset
	always_ff @(posedge clk) begin
		if (wrAccept && dec.hit && !dec.isDir) begin
			latch[dec.slot] <= apbReq.pwdata[7:0] & slotM;
		end
	end

	// ****************************************
	// Direction registers and driver enables
	// ****************************************

	// Direction bits, cleared by reset so every pin starts as input
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				dir[i] <= DIR_RESET;
			end
		end else if (wrAccept && dec.hit && dec.isDir) begin
			dir[dec.slot] <= apbReq.pwdata[7:0] & slotM;
		end
	end

	// Enables kept as their own flops so pin outputs come straight from a register
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				outEnN[i] <= OUT_EN_N_RESET;
			end
		end else if (wrAccept && dec.hit && dec.isDir) begin
			outEnN[dec.slot] <= ~(apbReq.pwdata[7:0] & slotM);
		end
	end

	// ****************************************
	// Pin outputs
	// ****************************************
	// Latch drives the pad whether or not enabled; the enable decides
	assign firstPortOut = latch[SLOT_FIRST];
	assign firstPortOutEnN = outEnN[SLOT_FIRST];
	assign secondPortOut = latch[SLOT_SECOND];
	assign secondPortOutEnN = outEnN[SLOT_SECOND];
	assign thirdPortOut = latch[SLOT_THIRD][6:0];
	assign thirdPortOutEnN = outEnN[SLOT_THIRD][6:0];
	assign fifthPortOut = latch[SLOT_FIFTH];
	assign fifthPortOutEnN = outEnN[SLOT_FIFTH];
	assign sixthPortOut = latch[SLOT_SIXTH][5:0];
	assign sixthPortOutEnN = outEnN[SLOT_SIXTH][5:0];

	// ****************************************
	// APB answer
	// ****************************************

	// Ready rises in the first access cycle: zero wait states always
	always_ff @(posedge clk) begin
		if (srst) begin
			pready <= 1'b0;
		end else begin
			pready <= apbReq.psel && !apbReq.penable;
		end
	end

	// Read data and error captured in the setup cycle, cleared otherwise
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (apbReq.psel && !apbReq.penable) begin
			prdata <= apbReq.pwrite ? 32'h0000_0000 : {24'h00_0000, rdValue};
			pslverr <= !dec.hit;
		end else begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence setupSeq;
		apbReq.psel && !apbReq.penable;
	endsequence
	sequence accessSeq;
		apbReq.psel && apbReq.penable && pready;
	endsequence
	// A read of a data register, seen in its setup cycle
	sequence dataReadSetup;
		apbReq.psel && !apbReq.penable && !apbReq.pwrite && dec.hit && !dec.isDir;
	endsequence
	// A read of a direction register, seen in its setup cycle
	sequence dirReadSetup;
		apbReq.psel && !apbReq.penable && !apbReq.pwrite && dec.hit && dec.isDir;
	endsequence

	// Leaving reset, every direction is clear and the first and sixth port drivers are off
	// Guards the reset branches of both the direction and the enable flops
	chk_dir_reset_clear: assert property ($fell(srst) |->
		(dir[0] == 8'h00 && dir[1] == 8'h00 && dir[2] == 8'h00 && dir[3] == 8'h00
		&& dir[4] == 8'h00 && firstPortOutEnN == 8'hFF && sixthPortOutEnN == 6'h3F))
		else $error("direction not cleared by reset");

	// The first and third port enables mirror the direction bits at every edge
	// A write that reached one copy but not the other would show here
	chk_enable_follows_dir: assert property (
		firstPortOutEnN == ~dir[SLOT_FIRST] && thirdPortOutEnN == ~dir[SLOT_THIRD][6:0])
		else $error("driver enable disagrees with direction");

	// A data write lands in the addressed latch on the completing edge
	// It lands whatever the direction holds, inputs included
	chk_latch_write: assert property ((wrAccept && dec.hit && !dec.isDir) |=>
		latch[$past(dec.slot)] == ($past(apbReq.pwdata[7:0]) & $past(slotM)))
		else $error("data write did not reach latch");

	// Mixed directions: a data read is the per-bit blend of latch and pin
	chk_read_mux: assert property (dataReadSetup ##1 accessSeq
		|-> prdata[7:0] == (readMux($past(latch[dec.slot]), $past(dir[dec.slot]),
		$past(pins[dec.slot])) & $past(slotM)))
		else $error("read returned wrong mix of latch and pin");

	// Upper data lanes and reserved direction bits always stay at zero
	// Masked writes are what keep the reserved positions clear
	chk_reserved_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000
		&& dir[SLOT_THIRD][7] == 1'b0 && dir[SLOT_SIXTH][7:6] == 2'b00)
		else $error("reserved bits not zero");

	// A hole in the map answers with an error and no data
	// Software sees the error in the same cycle as ready
	chk_unmapped_error: assert property ((setupSeq and !dec.hit) |=>
		(pslverr && pready && prdata == 32'h0000_0000))
		else $error("unmapped access not flagged");

	// Ready stands for exactly the one access cycle after setup
	// A longer pulse would complete a second transfer the master never made
	chk_ready_timing: assert property (setupSeq |=> pready ##1 !pready)
		else $error("ready not a single access cycle");

	// A direction read returns the register as it stood in the setup cycle
	chk_dir_readback: assert property (dirReadSetup |=>
		prdata[7:0] == $past(dir[dec.slot] & slotM))
		else $error("direction readback differs from register");

	// A direction write lands, masked to the implemented pins
	chk_dir_write: assert property ((wrAccept && dec.hit && dec.isDir) |=>
		dir[$past(dec.slot)] == ($past(apbReq.pwdata[7:0]) & $past(slotM)))
		else $error("direction write did not land");

	// Every pin whose direction bit is set is driven, on the other ports too
	chk_enable_other_ports: assert property (
		secondPortOutEnN == ~dir[SLOT_SECOND] && fifthPortOutEnN == ~dir[SLOT_FIFTH]
		&& sixthPortOutEnN == ~dir[SLOT_SIXTH][5:0])
		else $error("driver enable disagrees with direction");

	// A read with every pin an input returns the board levels alone
	chk_read_input: assert property ((dataReadSetup and (dir[dec.slot] == 8'h00)) |=>
		prdata[7:0] == $past(pins[dec.slot] & slotM))
		else $error("input read did not return the pins");

	// A read with every implemented pin an output returns the latch alone
	chk_read_latch: assert property ((dataReadSetup and (dir[dec.slot] == slotM)) |=>
		prdata[7:0] == $past(latch[dec.slot] & slotM))
		else $error("output read did not return the latch");

	// Data writes and writes to holes leave every direction alone
	chk_dir_ignores_data: assert property ((wrAccept && !dec.isDir) |=>
		$stable(dir[SLOT_FIRST]) && $stable(dir[SLOT_SECOND]) && $stable(dir[SLOT_THIRD])
		&& $stable(dir[SLOT_FIFTH]) && $stable(dir[SLOT_SIXTH]))
		else $error("direction changed by a data or unmapped write");

	// A read never disturbs a direction register
	chk_dir_ignores_read: assert property ((accessSeq and !apbReq.pwrite) |=>
		$stable(dir[SLOT_FIRST]) && $stable(dir[SLOT_SECOND]) && $stable(dir[SLOT_THIRD])
		&& $stable(dir[SLOT_FIFTH]) && $stable(dir[SLOT_SIXTH]))
		else $error("direction changed by a read");

	// Reset floats every pin by the next edge, whatever software had set
	chk_reset_floats_pins: assert property (disable iff (1'b0) srst |=>
		(firstPortOutEnN == 8'hFF && secondPortOutEnN == 8'hFF && thirdPortOutEnN == 7'h7F
		&& fifthPortOutEnN == 8'hFF && sixthPortOutEnN == 6'h3F))
		else $error("pins still driven after reset");

	// During reset the bus answer stays quiet
	chk_reset_quiet_bus: assert property (disable iff (1'b0) srst |=>
		(!pready && !pslverr && prdata == 32'h0000_0000))
		else $error("bus answer active during reset");

	// Outside the access cycle the answer lines rest at zero
	chk_idle_answer: assert property (!pready |-> (prdata == 32'h0000_0000 && !pslverr))
		else $error("answer lines not idle outside access");

	// An error is only ever shown together with ready
	chk_error_with_ready: assert property (pslverr |-> pready)
		else $error("error shown without ready");

	// An error answer never carries data
	chk_error_no_data: assert property (pslverr |-> prdata == 32'h0000_0000)
		else $error("error answer carried data");

	// Mapped registers always answer without error
	chk_mapped_no_error: assert property ((setupSeq and dec.hit) |=> !pslverr)
		else $error("mapped register answered with error");

	// Without a select there is never a ready
	chk_ready_needs_select: assert property (!apbReq.psel |=> !pready)
		else $error("ready without a transfer");

	// A write answer carries no read data
	chk_write_reads_zero: assert property ((setupSeq and apbReq.pwrite) |=>
		prdata == 32'h0000_0000)
		else $error("write answer carried data");
endmodule
`default_nettype wire

// ==== logic/gpio_ports_pkg.sv ====
// Constants, register map and carrier types of the parallel port block
`default_nettype none
package gpio_ports_pkg;
	// ****************************************
	// Register indices; byte address is four times the index
	// ****************************************
	localparam logic [3:0] IDX_FIRST_LATCH = 4'h0;
	localparam logic [3:0] IDX_SECOND_LATCH = 4'h1;
	localparam logic [3:0] IDX_THIRD_LATCH = 4'h2;
	localparam logic [3:0] IDX_FIRST_DIR = 4'h4;
	localparam logic [3:0] IDX_SECOND_DIR = 4'h5;
	localparam logic [3:0] IDX_THIRD_DIR = 4'h6;
	localparam logic [3:0] IDX_FIFTH_LATCH = 4'h8;
	localparam logic [3:0] IDX_SIXTH_LATCH = 4'h9;
	localparam logic [3:0] IDX_FIFTH_DIR = 4'hC;
	localparam logic [3:0] IDX_SIXTH_DIR = 4'hD;
	// ****************************************
	// Port slots and implemented-bit masks
	// ****************************************
	localparam int NUM_PORTS = 5;
	localparam logic [2:0] SLOT_FIRST = 3'h0;
	localparam logic [2:0] SLOT_SECOND = 3'h1;
	localparam logic [2:0] SLOT_THIRD = 3'h2;
	localparam logic [2:0] SLOT_FIFTH = 3'h3;
	localparam logic [2:0] SLOT_SIXTH = 3'h4;
	localparam logic [7:0] MASK_FIRST = 8'hFF;
	localparam logic [7:0] MASK_SECOND = 8'hFF;
	localparam logic [7:0] MASK_THIRD = 8'h7F;
	localparam logic [7:0] MASK_FIFTH = 8'hFF;
	localparam logic [7:0] MASK_SIXTH = 8'h3F;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] OUT_EN_N_RESET = 8'hFF;
	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;
	typedef struct packed {
		logic hit;
		logic isDir;
		logic [2:0] slot;
	} decode_type;
endpackage
`default_nettype wire

// ==== tb/pin_board.sv ====
// Board-side model of one port's pins
`default_nettype none
module pin_board #(
	parameter int W = 8 // Pins in this port
) (
	input wire logic [W-1:0] drive, // Values the block drives
	input wire logic [W-1:0] enN, // Driver enables, low drives
	input wire logic [W-1:0] board, // Level the board holds on floating pins
	output logic [W-1:0] level // Resolved pin level
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Pin resolution
	// ****************************************
	// A floating pin takes the board level, never the last driven value
	always_comb begin
		for (int b = 0; b < W; b++) begin
			level[b] = enN[b] ? board[b] : drive[b];
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the parallel port block
`default_nettype none
module tb_top import gpio_ports_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Stimulus, wiring and tables
	// ****************************************
	logic clk = 1'h0; // 100 ns period
	logic srst = 1'h1; // Reset, active high
	apb_req_type apbReq = '0; // Request to the block
	logic [7:0] board = 8'h00; // Level on floating pins
	wire logic [31:0] prdata; // Read data
	wire logic pready, pslverr; // Bus answer
	wire logic [7:0] aIn, aOut, aEn, bIn, bOut, bEn, eIn, eOut, eEn; // Full ports
	wire logic [6:0] cIn, cOut, cEn; // Seven-pin port
	wire logic [5:0] fIn, fOut, fEn; // Six-pin port
	wire logic [7:0] outs [5]; // Drive values, zero padded
	wire logic [7:0] ens [5]; // Enables, zero padded
	int fail_count = 0; // Mismatches
	int check_count = 0; // Comparisons
	localparam logic [3:0] LAT [5] = '{IDX_FIRST_LATCH, IDX_SECOND_LATCH, IDX_THIRD_LATCH,
		IDX_FIFTH_LATCH, IDX_SIXTH_LATCH};
	localparam logic [3:0] DIR [5] = '{IDX_FIRST_DIR, IDX_SECOND_DIR, IDX_THIRD_DIR,
		IDX_FIFTH_DIR, IDX_SIXTH_DIR};
	localparam logic [7:0] MSK [5] = '{MASK_FIRST, MASK_SECOND, MASK_THIRD, MASK_FIFTH, MASK_SIXTH};
	assign outs = '{aOut, bOut, {1'h0, cOut}, eOut, {2'h0, fOut}};
	assign ens = '{aEn, bEn, {1'h0, cEn}, eEn, {2'h0, fEn}};
	// Free-running clock
	always #50 clk = ~clk;
	bidirectional_gpio_ports i_dut (.clk(clk), .srst(srst), .apbReq(apbReq), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .firstPortIn(aIn), .firstPortOut(aOut),
		.firstPortOutEnN(aEn), .secondPortIn(bIn), .secondPortOut(bOut), .secondPortOutEnN(bEn),
		.thirdPortIn(cIn), .thirdPortOut(cOut), .thirdPortOutEnN(cEn), .fifthPortIn(eIn),
		.fifthPortOut(eOut), .fifthPortOutEnN(eEn), .sixthPortIn(fIn), .sixthPortOut(fOut),
		.sixthPortOutEnN(fEn));
	pin_board #(.W(8)) i_pinA (.drive(aOut), .enN(aEn), .board(board), .level(aIn));
	pin_board #(.W(8)) i_pinB (.drive(bOut), .enN(bEn), .board(board), .level(bIn));
	pin_board #(.W(7)) i_pinC (.drive(cOut), .enN(cEn), .board(board[6:0]), .level(cIn));
	pin_board #(.W(8)) i_pinE (.drive(eOut), .enN(eEn), .board(board), .level(eIn));
	pin_board #(.W(6)) i_pinF (.drive(fOut), .enN(fEn), .board(board[5:0]), .level(fIn));
	// ****************************************
	// Bus and checking tasks
	// ****************************************
	// One APB transfer; request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		apbReq <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: {2'h0, idx, 2'h0},
			pwdata: {24'h0, wd}};
		@(posedge clk);
		apbReq.penable <= 1'h1;
		n = 0;
		// Ready is judged only at rising edges, where the slave samples the request
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		// A slave that never answers ends the run
		if (pready !== 1'h1) begin
			fail_count++;
			wrap_up();
		end
		// Answer taken at the edge that saw ready; release in the same step
		rd = prdata;
		err = pslverr;
		apbReq <= '0;
	endtask
	task automatic wreg(input logic [3:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'h1, idx, d, rd, err);
	endtask
	task automatic rreg(input logic [3:0] idx, input logic [31:0] exp);
		logic [31:0] rd;
		logic err;
		apb(1'h0, idx, 8'h00, rd, err);
		check(rd, exp);
		check({31'h0, err}, 32'h0);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	// All pins float and directions read zero after reset
	task automatic scen_reset();
		@(negedge clk);
		foreach (MSK[i]) begin
			check({24'h0, ens[i] & MSK[i]}, {24'h0, MSK[i]});
			rreg(DIR[i], 32'h0);
		end
	endtask
	// All-ones direction: reserved bits stay zero, every implemented pin drives
	task automatic scen_dir();
		foreach (MSK[i]) begin
			wreg(DIR[i], 8'hFF);
			rreg(DIR[i], {24'h0, MSK[i]});
			check({24'h0, ens[i] & MSK[i]}, 32'h0);
			wreg(DIR[i], 8'h00);
		end
	endtask
	// Mixed directions: inputs read the pin, outputs read the latch
	task automatic scen_latch();
		foreach (MSK[i]) begin
			board <= 8'hA5;
			wreg(LAT[i], 8'h3C);
			rreg(LAT[i], {24'h0, 8'hA5 & MSK[i]});
			check({24'h0, outs[i]}, {24'h0, 8'h3C & MSK[i]});
			wreg(DIR[i], 8'hF0);
			rreg(LAT[i], {24'h0, 8'h35 & MSK[i]});
			check({24'h0, ens[i] & MSK[i]}, {24'h0, 8'h0F & MSK[i]});
			wreg(DIR[i], 8'h00);
		end
	endtask
	// A mid-run reset floats the pins but keeps the latch
	task automatic scen_keep();
		wreg(IDX_FIRST_LATCH, 8'h5A);
		wreg(IDX_FIRST_DIR, 8'hFF);
		srst <= 1'h1;
		repeat (2) @(posedge clk);
		srst <= 1'h0;
		@(negedge clk);
		check({24'h0, aOut}, 32'h5A);
		check({24'h0, aEn}, 32'hFF);
		wreg(IDX_FIRST_DIR, 8'hFF);
		rreg(IDX_FIRST_LATCH, 32'h5A);
	endtask
	// Holes in the map answer with an error and read zero
	task automatic scen_holes();
		logic [3:0] holes [4] = '{4'h3, 4'h7, 4'hA, 4'hB};
		logic [31:0] rd;
		logic err;
		foreach (holes[i]) begin
			apb(1'h1, holes[i], 8'hFF, rd, err);
			check({31'h0, err}, 32'h1);
			apb(1'h0, holes[i], 8'h00, rd, err);
			check(rd, 32'h0);
		end
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'h0;
		scen_reset();
		scen_dir();
		scen_latch();
		scen_keep();
		scen_holes();
		wrap_up();
	end
endmodule
`default_nettype wire
